// ### verilog/tlic_pkg.sv
// Purpose: Constants, register map and carrier types for the two-level interrupt controller
// Assumes: Avalon-MM slave with 32-bit data, word-aligned byte addresses
// Notes: Sources are numbered by their fixed tie-break order, 0 served first
//
// Overview of operation
// - Twenty-three sources, each with a pending flag software can read and write.
// - A source event sets its pending flag whether or not it is enabled.
// - Enabled pending source raises a request; core calls that source's fixed vector.
// - Return from interrupt resumes the interrupted program at its next instruction.
// - A pending flag without its enable raises no request at all.
// - Each source has its own enable bit in one of three enable registers.
// - Global enable, bit 7 of enable register A, gates every individual enable.
// - Request during an enable clear may be taken only before a single-cycle instruction.
// - Some flags clear by hardware on vectoring; the rest software clears before returning.
// - A flag still set after return raises a new request at once.
// - Software writing 1 to a pending flag acts exactly like a hardware event.
// - Each source has a priority bit, low or high, resetting to low.
// - High priority preempts a low routine; nothing preempts a high routine.
// - Simultaneous requests: higher level first, ties by fixed source order.
// - Requests sampled and decoded each cycle; fastest response one cycle plus call.
// - After a return, exactly one further instruction runs before the next call.
// - Equal or lower priority waits until the routine returns plus one instruction.
// - Reset vectors to 0x0000; index n vectors to 0x0003 plus eight times n.
package tlic_pkg;
  localparam int unsigned NUM_SRC = 23;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned VEC_W = 16;
  // Register byte offsets
  localparam logic [5:0] ADDR_PEND = 6'h00;
  localparam logic [5:0] ADDR_PEND_SET = 6'h04;
  localparam logic [5:0] ADDR_PEND_CLR = 6'h08;
  localparam logic [5:0] ADDR_EN_A = 6'h0C;
  localparam logic [5:0] ADDR_EN_B = 6'h10;
  localparam logic [5:0] ADDR_EN_C = 6'h14;
  localparam logic [5:0] ADDR_PRI_A = 6'h18;
  localparam logic [5:0] ADDR_PRI_B = 6'h1C;
  localparam logic [5:0] ADDR_PRI_C = 6'h20;
  localparam logic [5:0] ADDR_STATUS = 6'h24;
  // Field layout: register A holds sources 0..6 and the global enable at bit 7
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned GRP_A_LSB = 0;
  localparam int unsigned GRP_A_N = 7;
  localparam int unsigned GRP_B_LSB = 7;
  localparam int unsigned GRP_C_LSB = 15;
  localparam int unsigned GRP_BC_N = 8;
  // Vector table
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [VEC_W-1:0] VECTOR_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VECTOR_STEP = 16'h0008;
  // Default for sources whose flag hardware clears on vectoring (0,1,2,3,16)
  localparam logic [NUM_SRC-1:0] AUTO_CLR_DEFAULT = 23'h01000F;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Core-side states, Gray coded along the usual idle-call-hold path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_HOLD = 2'b11
  } tlic_state_e;

  // Vector call offered to the core
  typedef struct packed {
    logic [VEC_W-1:0] vector;
    logic [IDX_W-1:0] index;
    logic high;
  } tlic_call_s;
endpackage

// ### verilog/tlic_arbiter.sv
// Purpose: Two-level fixed-order arbiter for interrupt requests
// Assumes: Bit 0 of the request vector is the first in tie-break order
// Notes: Purely combinational, decoded afresh on every cycle
`timescale 1ns/100ps
`default_nettype none
module tlic_arbiter #(
  parameter int unsigned N = tlic_pkg::NUM_SRC
) (
  input wire logic [N-1:0] i_req,
  input wire logic [N-1:0] i_high,
  output logic o_valid,
  output logic o_high,
  output logic [tlic_pkg::IDX_W-1:0] o_index
);
  // Lowest set bit wins inside a level
  function automatic logic [tlic_pkg::IDX_W-1:0] first_set(input logic [N-1:0] v);
    logic [tlic_pkg::IDX_W-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = tlic_pkg::IDX_W'(i);
    end
    return idx;
  endfunction

  wire logic [N-1:0] req_hi = i_req & i_high;
  wire logic [N-1:0] req_lo = i_req & ~i_high;
  wire logic any_hi = |req_hi;

  // High level checked before the tie-break order
  assign o_valid = |i_req;
  assign o_high = any_hi;
  assign o_index = any_hi ? first_set(req_hi) : first_set(req_lo);
endmodule
`default_nettype wire

// ### verilog/tlic_top.sv
// Purpose: Two-level interrupt controller with pending, enable and priority registers
// Assumes: Core pulses i_instr_done at each instruction end and i_irq_return at each return
// Notes: The core samples o_call_req at an instruction boundary and answers with i_call_ack
`timescale 1ns/100ps
`default_nettype none
module tlic_top #(
  parameter logic [tlic_pkg::NUM_SRC-1:0] AUTO_CLR = tlic_pkg::AUTO_CLR_DEFAULT
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Avalon-MM slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Peripheral events, one-cycle pulses or levels
  input wire logic [tlic_pkg::NUM_SRC-1:0] i_src_event,
  // Core handshake
  input wire logic i_instr_done,
  input wire logic i_multi_cycle,
  input wire logic i_call_ack,
  input wire logic i_irq_return,
  output logic o_call_req,
  output logic [tlic_pkg::VEC_W-1:0] o_call_vector,
  output logic [tlic_pkg::IDX_W-1:0] o_call_index,
  output logic o_call_high,
  output logic [tlic_pkg::VEC_W-1:0] o_reset_vector,
  output logic [1:0] o_in_service
);
  localparam int unsigned N = tlic_pkg::NUM_SRC;

  // Vector address for a priority-order index
  function automatic logic [tlic_pkg::VEC_W-1:0] vec_of(input logic [tlic_pkg::IDX_W-1:0] idx);
    logic [tlic_pkg::VEC_W-1:0] off;
    off = tlic_pkg::VEC_W'(idx) * tlic_pkg::VECTOR_STEP;
    return tlic_pkg::VECTOR_BASE + off;
  endfunction

  // Packs per-source bits into register A, B or C layout
  function automatic logic [7:0] grp_pack(input logic [N-1:0] v, input logic [1:0] g);
    logic [7:0] r;
    r = '0;
    unique case (g)
      2'd0: r = {1'b0, v[tlic_pkg::GRP_A_LSB +: tlic_pkg::GRP_A_N]};
      2'd1: r = v[tlic_pkg::GRP_B_LSB +: tlic_pkg::GRP_BC_N];
      default: r = v[tlic_pkg::GRP_C_LSB +: tlic_pkg::GRP_BC_N];
    endcase
    return r;
  endfunction

  // Register state
  logic [N-1:0] pend_ff;
  logic [N-1:0] en_ff;
  logic [N-1:0] pri_ff;
  logic global_en_ff;
  logic [1:0] in_service_ff;
  logic [31:0] rdata_ff;
  logic rd_ack_ff;
  tlic_pkg::tlic_state_e state_ff;
  tlic_pkg::tlic_call_s call_ff;
  logic block_ff;
  logic [1:0] after_ret_ff;

  // Bus decode
  wire logic wr_lo = i_avs_write & i_avs_byteenable[0];
  wire logic wr_b1 = i_avs_write & i_avs_byteenable[1];
  wire logic wr_b2 = i_avs_write & i_avs_byteenable[2];
  wire logic [N-1:0] wmask = {{7{wr_b2}}, {8{wr_b1}}, {8{wr_lo}}};
  wire logic [N-1:0] wdata = i_avs_writedata[N-1:0];
  wire logic hit_pend = i_avs_address == tlic_pkg::ADDR_PEND;
  wire logic hit_set = i_avs_address == tlic_pkg::ADDR_PEND_SET;
  wire logic hit_clr = i_avs_address == tlic_pkg::ADDR_PEND_CLR;
  wire logic hit_en_a = wr_lo && i_avs_address == tlic_pkg::ADDR_EN_A;
  wire logic hit_en_b = wr_lo && i_avs_address == tlic_pkg::ADDR_EN_B;
  wire logic hit_en_c = wr_lo && i_avs_address == tlic_pkg::ADDR_EN_C;
  wire logic hit_pri_a = wr_lo && i_avs_address == tlic_pkg::ADDR_PRI_A;
  wire logic hit_pri_b = wr_lo && i_avs_address == tlic_pkg::ADDR_PRI_B;
  wire logic hit_pri_c = wr_lo && i_avs_address == tlic_pkg::ADDR_PRI_C;

  // Writes take one cycle; reads wait one cycle for registered data
  assign o_avs_waitrequest = i_avs_read & ~rd_ack_ff;
  assign o_avs_readdata = rdata_ff;

  // Pending: writing 1 to the direct or set address posts an event
  wire logic [N-1:0] sw_set = ((hit_pend | hit_set) ? wdata & wmask : '0);
  // Direct write of 0 or the clear address retires a flag
  wire logic [N-1:0] sw_clr = (hit_pend ? ~wdata & wmask : '0) |
                              (hit_clr ? wdata & wmask : '0);
  wire logic take = (state_ff == tlic_pkg::ST_CALL) & i_call_ack;
  wire logic [N-1:0] one_hot = N'(1) << call_ff.index;
  // Hardware clears only flags of auto-clear sources, on the vector call
  wire logic [N-1:0] hw_clr = take ? (one_hot & AUTO_CLR) : '0;
  // Events set regardless of enable, and win over any clear in the same cycle
  wire logic [N-1:0] nxt_pend = (pend_ff & ~(sw_clr | hw_clr)) | i_src_event | sw_set;

  // Enables and priorities in the three register groups
  // Group C carries eight sources, so its lane is a full byte
  wire logic [N-1:0] en_wmask = {{8{hit_en_c}}, {8{hit_en_b}}, {7{hit_en_a}}};
  wire logic [N-1:0] pri_wmask = {{8{hit_pri_c}}, {8{hit_pri_b}}, {7{hit_pri_a}}};
  wire logic [N-1:0] wgrp = {i_avs_writedata[7:0], i_avs_writedata[7:0],
                             i_avs_writedata[6:0]};
  wire logic [N-1:0] nxt_en = (en_ff & ~en_wmask) | (wgrp & en_wmask);
  wire logic [N-1:0] nxt_pri = (pri_ff & ~pri_wmask) | (wgrp & pri_wmask);
  wire logic nxt_global_en = hit_en_a ? i_avs_writedata[tlic_pkg::GLOBAL_EN_BIT]
                                      : global_en_ff;

  // Request: a pending flag counts only with its enable and the global enable
  wire logic [N-1:0] req = global_en_ff ? (pend_ff & en_ff) : '0;
  wire logic arb_valid;
  wire logic arb_high;
  wire logic [tlic_pkg::IDX_W-1:0] arb_index;

  // Decoded every cycle from the current flags
  tlic_arbiter #(
    .N(N)
  ) u_arb (
    .i_req(req),
    .i_high(pri_ff),
    .o_valid(arb_valid),
    .o_high(arb_high),
    .o_index(arb_index)
  );

  // High may preempt only an idle or low level; low only an idle core
  wire logic may_preempt = arb_high ? ~in_service_ff[1] : (in_service_ff == 2'b00);
  // After a return exactly one instruction must finish before a new call
  // At 1 the next instruction end may already start the call
  wire logic ret_gate = after_ret_ff == 2'd2;
  wire logic eligible = arb_valid & may_preempt & ~ret_gate;
  // An enable cleared just before a multi-cycle instruction holds the request off
  wire logic cleared_en = (|(en_ff & ~nxt_en)) | (global_en_ff & ~nxt_global_en);
  wire logic nxt_block = cleared_en | (block_ff & ~i_instr_done);
  wire logic gate_ok = ~(block_ff & i_multi_cycle);

  // Call offer waits for an instruction boundary
  tlic_pkg::tlic_state_e nxt_state;
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      tlic_pkg::ST_IDLE: if (eligible & i_instr_done & gate_ok) nxt_state = tlic_pkg::ST_CALL;
      tlic_pkg::ST_CALL: if (i_call_ack) nxt_state = tlic_pkg::ST_HOLD;
      tlic_pkg::ST_HOLD: nxt_state = tlic_pkg::ST_IDLE;
      default: nxt_state = tlic_pkg::ST_IDLE;
    endcase
  end

  // Call details latched from the arbiter when the offer starts
  wire logic start = (state_ff == tlic_pkg::ST_IDLE) & (nxt_state == tlic_pkg::ST_CALL);
  wire tlic_pkg::tlic_call_s nxt_call = start ? tlic_pkg::tlic_call_s'{
                                                  vector: vec_of(arb_index),
                                                  index: arb_index,
                                                  high: arb_high} : call_ff;

  // Markers: set per level on call, the highest active cleared on return
  wire logic [1:0] set_mark = take ? (call_ff.high ? 2'b10 : 2'b01) : 2'b00;
  wire logic [1:0] ret_mark = ~i_irq_return ? 2'b00 :
                              (in_service_ff[1] ? 2'b10 : 2'b01);
  wire logic [1:0] nxt_in_service = (in_service_ff & ~ret_mark) | set_mark;
  // Count: 2 after return, 1 once the return itself ends, 0 after one more instruction
  wire logic [1:0] nxt_after_ret = i_irq_return ? 2'd2 :
                                   (i_instr_done && after_ret_ff != 2'd0) ?
                                   after_ret_ff - 2'd1 : after_ret_ff;

  // Read mux
  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = tlic_pkg::RD_UNMAPPED;
    unique case (i_avs_address)
      tlic_pkg::ADDR_PEND: nxt_rdata = 32'(pend_ff);
      tlic_pkg::ADDR_EN_A: nxt_rdata = {24'h000000, global_en_ff,
                                        en_ff[tlic_pkg::GRP_A_LSB +: tlic_pkg::GRP_A_N]};
      tlic_pkg::ADDR_EN_B: nxt_rdata = 32'(grp_pack(en_ff, 2'd1));
      tlic_pkg::ADDR_EN_C: nxt_rdata = 32'(grp_pack(en_ff, 2'd2));
      tlic_pkg::ADDR_PRI_A: nxt_rdata = 32'(grp_pack(pri_ff, 2'd0));
      tlic_pkg::ADDR_PRI_B: nxt_rdata = 32'(grp_pack(pri_ff, 2'd1));
      tlic_pkg::ADDR_PRI_C: nxt_rdata = 32'(grp_pack(pri_ff, 2'd2));
      tlic_pkg::ADDR_STATUS: nxt_rdata = {23'h000000, call_ff.index, state_ff, in_service_ff};
      default: nxt_rdata = tlic_pkg::RD_UNMAPPED;
    endcase
  end
  wire logic nxt_rd_ack = i_avs_read & ~rd_ack_ff;

  // Register bank; priority bits reset to low
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pend_ff <= '0;
      en_ff <= '0;
      pri_ff <= '0;
      global_en_ff <= 1'b0;
      rdata_ff <= '0;
      rd_ack_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      en_ff <= nxt_en;
      pri_ff <= nxt_pri;
      global_en_ff <= nxt_global_en;
      rdata_ff <= nxt_rdata;
      rd_ack_ff <= nxt_rd_ack;
    end
  end

  // Sequencing state
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_ff <= tlic_pkg::ST_IDLE;
      call_ff <= '0;
      in_service_ff <= 2'b00;
      block_ff <= 1'b0;
      after_ret_ff <= 2'd0;
    end
    else
    begin
      state_ff <= nxt_state;
      call_ff <= nxt_call;
      in_service_ff <= nxt_in_service;
      block_ff <= nxt_block;
      after_ret_ff <= nxt_after_ret;
    end
  end

  // Core-facing outputs
  assign o_call_req = state_ff == tlic_pkg::ST_CALL;
  assign o_call_vector = call_ff.vector;
  assign o_call_index = call_ff.index;
  assign o_call_high = call_ff.high;
  assign o_reset_vector = tlic_pkg::RESET_VECTOR;
  assign o_in_service = in_service_ff;
endmodule
`default_nettype wire

// ### verification/tlic_monitor.sv
// Purpose: Port assertions for the interrupt controller
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached to tlic_top by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module tlic_monitor (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_instr_done,
  input wire logic i_call_ack,
  input wire logic i_irq_return,
  input wire logic o_call_req,
  input wire logic [15:0] o_call_vector,
  input wire logic [4:0] o_call_index,
  input wire logic o_call_high,
  input wire logic [15:0] o_reset_vector,
  input wire logic [1:0] o_in_service
);
  logic [1:0] ret_gap_ff;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Instructions ended since the last return; saturates so idle time never wraps it
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n) ret_gap_ff <= 2'h3;
    else if (i_irq_return) ret_gap_ff <= 2'h0;
    else if (i_instr_done && ret_gap_ff != 2'h3) ret_gap_ff <= ret_gap_ff + 2'h1;
  a_reset_vector: assert property (o_reset_vector == 16'h0000)
    else $error("reset vector not zero");
  a_vector_map: assert property (
    o_call_req |-> o_call_vector == 16'h0003 + {8'h00, o_call_index, 3'b000})
    else $error("call vector does not match index");
  a_req_hold: assert property (
    o_call_req && !i_call_ack |=> o_call_req && $stable(o_call_index))
    else $error("call offer changed before ack");
  a_ack_drop: assert property (o_call_req && i_call_ack |=> !o_call_req)
    else $error("call offer stayed after ack");
  a_marker_set: assert property (
    o_call_req && i_call_ack |=> o_in_service[$past(o_call_high)])
    else $error("in-service marker not set");
  a_high_alone: assert property (o_in_service[1] |-> !o_call_req)
    else $error("call offered during high service");
  a_low_preempt: assert property (o_in_service[0] && o_call_req |-> o_call_high)
    else $error("low call offered during service");
  a_req_cause: assert property ($rose(o_call_req) |-> $past(i_instr_done))
    else $error("call offered off an instruction end");
  a_return_gap: assert property ($rose(o_call_req) |-> ret_gap_ff >= 2'h2)
    else $error("call offered too soon after return");
  a_read_wait: assert property (
    $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("read wait cycle wrong");
  a_write_nowait: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write stalled");
  c_preempt: cover property (o_in_service == 2'b11);
  c_high_call: cover property ($rose(o_call_req) && o_call_high);
  c_reentry: cover property ($rose(o_call_req) && ret_gap_ff == 2'h2);
endmodule
bind tlic_top tlic_monitor mon_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_instr_done(i_instr_done), .i_call_ack(i_call_ack), .i_irq_return(i_irq_return),
  .o_call_req(o_call_req), .o_call_vector(o_call_vector), .o_call_index(o_call_index),
  .o_call_high(o_call_high), .o_reset_vector(o_reset_vector), .o_in_service(o_in_service));
`default_nettype wire

// ### verification/tlic_core_model.sv
// Purpose: Behavioural processor core facing the interrupt controller
// Assumes: Bench pulses i_ret_cmd for one cycle to run a return
// Notes: Slow mode ends an instruction only every fourth cycle
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_call_req,
  input wire logic i_slow,
  input wire logic i_ret_cmd,
  output logic o_instr_done,
  output logic o_call_ack,
  output logic o_irq_return
);
  logic [1:0] step_ff;
  wire tick = !i_slow || step_ff == 2'h3;
  // No instruction ends while a call runs or in the return's own cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      step_ff <= 2'h0;
      o_instr_done <= 1'b0;
      o_call_ack <= 1'b0;
      o_irq_return <= 1'b0;
    end
    else
    begin
      step_ff <= step_ff + 2'h1;
      o_instr_done <= tick && !i_call_req && !i_ret_cmd;
      o_call_ack <= tick && i_call_req && !o_call_ack;
      o_irq_return <= i_ret_cmd;
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Reference model tracks pending, enables, priorities and markers
// Notes: Byte enables are tied off; the multi-cycle hint is random in each of the 40 random trials, low before them
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [5:0] avs_addr = 6'h00;
  logic avs_rd = 1'b0, avs_wr = 1'b0, slow = 1'b0, ret_cmd = 1'b0, multi = 1'b0;
  logic [31:0] avs_wdata = 32'h0, avs_rdata, rdv;
  logic [22:0] src_event = 23'h0, m_pend, m_en, m_pri;
  logic avs_wait, instr_done, call_ack, irq_return, call_req, call_high, m_glob;
  logic [15:0] call_vec;
  logic [4:0] call_idx;
  logic [1:0] in_svc, m_svc = 2'h0;
  logic [5:0] offs[7] = '{6'h00, 6'h0C, 6'h10, 6'h14, 6'h1C, 6'h24, 6'h3C};
  int n_fail = 0, n_compared = 0, cyc = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  tlic_top dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_avs_address(avs_addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
    .i_src_event(src_event), .i_instr_done(instr_done), .i_multi_cycle(multi),
    .i_call_ack(call_ack), .i_irq_return(irq_return), .o_call_req(call_req),
    .o_call_vector(call_vec), .o_call_index(call_idx), .o_call_high(call_high),
    .o_reset_vector(), .o_in_service(in_svc));
  tlic_core_model core_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_call_req(call_req),
    .i_slow(slow), .i_ret_cmd(ret_cmd), .o_instr_done(instr_done), .o_call_ack(call_ack),
    .o_irq_return(irq_return));
  // Hang guard; the run needs far fewer cycles than this
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      $display("MISMATCH t=%0t cycle limit reached", $time);
      test_done();
    end
  end
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; held until waitrequest is seen low, then a idle cycle
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_addr <= a;
    avs_wdata <= d;
    avs_wr <= wr;
    avs_rd <= !wr;
    @(posedge i_ref_clk);
    while (avs_wait !== 1'b0) @(posedge i_ref_clk);
    rdv = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // Winner by level first, then fixed source order; low waits on any marker
  function automatic int pick();
    for (int lv = 1; lv >= 0; lv--)
      for (int i = 0; i < 23; i++)
        if (m_glob && m_en[i] && m_pend[i] && m_pri[i] == lv && !m_svc[1] && (lv == 1 || !m_svc[0]))
          return i;
    return -1;
  endfunction
  task automatic take_calls();
    int k;
    int w;
    for (k = pick(); k >= 0; k = pick())
    begin
      for (w = 0; call_req !== 1'b1 && w < 60; w++) @(posedge i_ref_clk);
      chk(call_req, 1);
      chk(call_idx, k);
      chk(call_vec, 3 + 8 * k);
      chk(call_high, m_pri[k]);
      while (call_req === 1'b1) @(posedge i_ref_clk);
      m_svc[m_pri[k]] = 1'b1;
      if (tlic_pkg::AUTO_CLR_DEFAULT[k]) m_pend[k] = 1'b0;
    end
    repeat (12) @(posedge i_ref_clk);
    chk(call_req, 0);
    bus(0, tlic_pkg::ADDR_PEND, 0);
    chk(rdv, m_pend);
    bus(0, tlic_pkg::ADDR_STATUS, 0);
    chk(rdv[1:0], m_svc);
  endtask
  // Return from the current routine, clearing all flags first unless kept
  task automatic ret(input bit keep);
    if (!keep) bus(1, tlic_pkg::ADDR_PEND_CLR, 32'h007FFFFF);
    if (!keep) m_pend = 0;
    ret_cmd <= 1'b1;
    @(posedge i_ref_clk);
    ret_cmd <= 1'b0;
    if (m_svc[1]) m_svc[1] = 1'b0;
    else m_svc[0] = 1'b0;
    take_calls();
  endtask
  task automatic trial(input logic [22:0] en, pri, pend, pend2, input bit glob, ev, keep);
    bus(1, tlic_pkg::ADDR_PEND_CLR, 32'h007FFFFF);
    m_pend = pend;
    m_en = en;
    m_pri = pri;
    m_glob = glob;
    bus(1, tlic_pkg::ADDR_EN_A, {24'h0, glob, en[6:0]});
    bus(1, tlic_pkg::ADDR_EN_B, {24'h0, en[14:7]});
    bus(1, tlic_pkg::ADDR_EN_C, {24'h0, en[22:15]});
    bus(1, tlic_pkg::ADDR_PRI_A, {25'h0, pri[6:0]});
    bus(1, tlic_pkg::ADDR_PRI_B, {24'h0, pri[14:7]});
    bus(1, tlic_pkg::ADDR_PRI_C, {24'h0, pri[22:15]});
    src_event <= ev ? pend : 23'h0;
    @(posedge i_ref_clk);
    src_event <= 23'h0;
    if (!ev) bus(1, tlic_pkg::ADDR_PEND_SET, {9'h0, pend});
    take_calls();
    m_pend = m_pend | pend2;
    bus(1, tlic_pkg::ADDR_PEND_SET, {9'h0, pend2});
    take_calls();
    if (m_svc != 2'h0) ret(keep);
    while (m_svc != 2'h0) ret(0);
  endtask
  initial
  begin
    rdv = $urandom(39360);
    repeat (5) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    bus(1, 6'h3C, 32'hFFFFFFFF);
    foreach (offs[i])
    begin
      bus(0, offs[i], 0);
      chk(rdv, 0);
    end
    for (int n = 0; n < 23; n++) trial(23'h1 << n, 0, 23'h1 << n, 0, 1, n[0], 0);
    trial(23'h7FFFFF, 0, 23'h7FFFFF, 0, 0, 0, 0);
    trial(0, 23'h7FFFFF, 23'($urandom), 0, 1, 1, 0);
    trial(23'h7FFFFF, 23'h000100, 23'h000020, 23'h000140, 1, 0, 1);
    repeat (40)
    begin
      slow <= 1'($urandom);
      // Enable writes may meet a multi-cycle follow-up, delaying a call
      multi <= 1'($urandom);
      trial(23'($urandom), 23'($urandom), 23'($urandom), 23'($urandom), 1, 1'($urandom),
        1'($urandom));
    end
    test_done();
  end
endmodule
`default_nettype wire
